// ---- rtl/smspi_consts.vh ----
`ifndef SMSPI_CONSTS_VH
`define SMSPI_CONSTS_VH
`define SMSPI_MODE_DIV4    3'h0
`define SMSPI_MODE_DIV16   3'h1
`define SMSPI_MODE_DIV64   3'h2
`define SMSPI_MODE_SUB     3'h3
`define SMSPI_MODE_TMR     3'h4
`define SMSPI_MODE_I2C     3'h6
`define SMSPI_MODE_RST     3'h7
`define SMSPI_HALF_DIV4    6'h01
`define SMSPI_HALF_DIV16   6'h07
`define SMSPI_HALF_DIV64   6'h1F
`define SMSPI_BITS         3'h7
`define SMSPI_FIFO_DEPTH   8
`define SMSPI_FIFO_AW      3
`endif

// ---- rtl/smspi_fifo.v ----
`timescale 1ns/1ns
`include "smspi_consts.vh"
module smspi_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = `SMSPI_FIFO_DEPTH,
  parameter AW    = `SMSPI_FIFO_AW
) (
  input  wire             sys_clk_in,
  input  wire             rst_b_in,
  input  wire [WIDTH-1:0] wr_data_in,
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  output wire [WIDTH-1:0] rd_data_out,
  output wire             rd_valid_out,
  input  wire             rd_ready_in
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wp_q;
  reg [AW-1:0]    rp_q;
  reg [AW:0]      cnt_q;
  wire push = wr_valid_in && wr_ready_out;
  wire pop  = rd_valid_out && rd_ready_in;
  assign wr_ready_out = (cnt_q != DEPTH[AW:0]);
  assign rd_valid_out = (cnt_q != {(AW+1){1'b0}});
  assign rd_data_out  = mem_q[rp_q];
  always @(posedge sys_clk_in) begin
    if (push) begin
      mem_q[wp_q] <= wr_data_in;
    end
  end
  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// ---- rtl/smspi_master.v ----
`timescale 1ns/1ns
`include "smspi_consts.vh"
// Behaviour
// - a three-bit mode input picks SPI master clocks or the I2C function for the shared pins.
// - a single enable input switches SPI transfers and the sck, sdo and pull-up pins on or off; writes still enter the buffer while disabled.
// - the block is master only and receives one bit for every bit it sends.
// - transfers are only ever started by this master.
// - the master drives the serial clock line for every transfer.
// - the link uses data in, data out, clock and a general-purpose select pin.
// - the shift order is selectable as lsb first or msb first.
// - the capture edge is selectable as rising or falling.
// - pull-ups on the serial pins act only when enabled and the pin is a module input.
// - pin roles depend on mode and enable; sck, sdo and the sdi pull-up are released while disabled, but the select pin stays driven.
// - mode codes give fsys/4, /16, /64, sub clock, half timer rate, or I2C.
// - polarity sets the clock idle level and the edge bit chooses capture edge relative to it.
// - a data write during a transfer is ignored and sets a sticky collision flag.
// - a completion flag sets at the end of each transfer and only software clears it.
module smspi_master (
  input  wire       sys_clk_in,
  input  wire       rst_b_in,
  input  wire [2:0] serial_mode_select_in,
  input  wire       serial_module_enable_in,
  input  wire       clock_idle_level_select_in,
  input  wire       clock_capture_edge_select_in,
  input  wire       shift_order_select_in,
  input  wire       sub_clock_in,
  input  wire       timer_period_match_in,
  input  wire       slave_select_level_in,
  input  wire [7:0] wr_data_in,
  input  wire       wr_valid_in,
  output reg        wr_ready_out,
  output reg  [7:0] serial_shift_data_out,
  output reg  [7:0] rx_data_out,
  output reg        rx_valid_out,
  input  wire       rx_ready_in,
  input  wire       write_collision_clear_in,
  input  wire       transfer_complete_clear_in,
  output reg        write_collision_flag_out,
  output reg        transfer_complete_flag_out,
  output reg        busy_out,
  input  wire       sdi_in,
  output reg        sdo_out,
  output reg        sdo_oe_out,
  output reg        sck_out,
  output reg        sck_oe_out,
  output reg        sdi_pullup_out,
  output reg        slave_select_out,
  output reg        slave_select_oe_out
);
  localparam ST_IDLE = 3'b001;
  localparam ST_LEAD = 3'b010;
  localparam ST_TRAIL = 3'b100;

  reg [2:0] state_q;
  reg [5:0] div_q;
  reg [2:0] bit_q;
  reg [7:0] tx_q;
  reg [7:0] rx_q;
  reg       sub_q;
  reg       tmr_q;
  reg       start_q;

  wire [7:0] fifo_data;
  wire       fifo_valid;
  wire       fifo_ready;
  wire [7:0] fifo_in_data;
  wire       fifo_in_valid;
  wire       fifo_in_ready;

  wire spi_mode = (serial_mode_select_in <= `SMSPI_MODE_TMR);
  wire active = spi_mode && serial_module_enable_in;
  wire idle_lvl = ~clock_idle_level_select_in;
  // edge bit set means leading capture, either polarity
  wire cap_lead = clock_capture_edge_select_in;

  function [5:0] half_limit;
    input [2:0] mode;
    begin
      case (mode)
        `SMSPI_MODE_DIV16: half_limit = `SMSPI_HALF_DIV16;
        `SMSPI_MODE_DIV64: half_limit = `SMSPI_HALF_DIV64;
        default:           half_limit = `SMSPI_HALF_DIV4;
      endcase
    end
  endfunction

  function out_bit;
    input [7:0] d;
    input       msb;
    begin
      out_bit = msb ? d[7] : d[0];
    end
  endfunction

  // one sampled bit into the byte
  function [7:0] rx_shift;
    input [7:0] d;
    input       b;
    input       msb;
    begin
      rx_shift = msb ? {d[6:0], b} : {b, d[7:1]};
    end
  endfunction

  function [7:0] tx_shift;
    input [7:0] d;
    input       msb;
    begin
      tx_shift = msb ? {d[6:0], 1'b0} : {1'b0, d[7:1]};
    end
  endfunction

  reg tick;
  always @* begin
    case (serial_mode_select_in)
      `SMSPI_MODE_SUB: tick = (sub_clock_in != sub_q);
      `SMSPI_MODE_TMR: tick = tmr_q;
      default:         tick = (div_q == half_limit(serial_mode_select_in));
    endcase
  end

  // buffered byte leaves only when it can start, so an unread byte loses nothing
  assign fifo_ready = active && (state_q == ST_IDLE) && !start_q && (!rx_valid_out || rx_ready_in);

  // writes during a transfer are refused
  wire collide = wr_valid_in && active && (state_q != ST_IDLE);
  assign fifo_in_valid = wr_valid_in && !collide;
  assign fifo_in_data  = wr_data_in;

  smspi_fifo #(
    .WIDTH (8),
    .DEPTH (`SMSPI_FIFO_DEPTH),
    .AW    (`SMSPI_FIFO_AW)
  ) smspi_fifo_inst (
    .sys_clk_in   (sys_clk_in),
    .rst_b_in     (rst_b_in),
    .wr_data_in   (fifo_in_data),
    .wr_valid_in  (fifo_in_valid),
    .wr_ready_out (fifo_in_ready),
    .rd_data_out  (fifo_data),
    .rd_valid_out (fifo_valid),
    .rd_ready_in  (fifo_ready)
  );

  wire done_now = (state_q == ST_TRAIL) && tick && (bit_q == `SMSPI_BITS);
  // received bytes stall the shifter when the reader holds off
  wire can_start = fifo_valid && fifo_ready && (!rx_valid_out || rx_ready_in);

  always @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q <= ST_IDLE;
      div_q <= 6'h00;
      bit_q <= 3'h0;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      sub_q <= 1'b0;
      tmr_q <= 1'b0;
      start_q <= 1'b0;
      wr_ready_out <= 1'b0;
      serial_shift_data_out <= 8'h00;
      rx_data_out <= 8'h00;
      rx_valid_out <= 1'b0;
      write_collision_flag_out <= 1'b0;
      transfer_complete_flag_out <= 1'b0;
      busy_out <= 1'b0;
      sdo_out <= 1'b0;
      sdo_oe_out <= 1'b0;
      sck_out <= 1'b1;
      sck_oe_out <= 1'b0;
      sdi_pullup_out <= 1'b0;
      slave_select_out <= 1'b0;
      slave_select_oe_out <= 1'b0;
    end else begin
      sub_q <= sub_clock_in;
      // one match per half period gives sck at half the match rate
      tmr_q <= timer_period_match_in;
      div_q <= (tick || state_q == ST_IDLE) ? 6'h00 : div_q + 6'h01;
      wr_ready_out <= fifo_in_ready && active;
      if (rx_valid_out && rx_ready_in) begin
        rx_valid_out <= 1'b0;
      end
      slave_select_out <= slave_select_level_in;
      slave_select_oe_out <= 1'b1;
      sdo_oe_out <= active;
      sck_oe_out <= active;
      sdi_pullup_out <= active;
      if (collide) begin
        write_collision_flag_out <= 1'b1;
      end else if (write_collision_clear_in) begin
        write_collision_flag_out <= 1'b0;
      end
      // set on completion, set beats clear
      if (done_now) begin
        transfer_complete_flag_out <= 1'b1;
      end else if (transfer_complete_clear_in) begin
        transfer_complete_flag_out <= 1'b0;
      end
      start_q <= 1'b0;
      if (!active) begin
        state_q <= ST_IDLE;
        busy_out <= 1'b0;
        sck_out <= idle_lvl;
      end else begin
        case (state_q)
          ST_IDLE: begin
            sck_out <= idle_lvl;
            // only a write starts a byte
            if (can_start) begin
              tx_q <= fifo_data;
              serial_shift_data_out <= fifo_data;
              sdo_out <= out_bit(fifo_data, shift_order_select_in);
              bit_q <= 3'h0;
              busy_out <= 1'b1;
              start_q <= 1'b1;
              state_q <= ST_LEAD;
            end
          end
          ST_LEAD: begin
            if (tick) begin
              sck_out <= ~idle_lvl;
              if (cap_lead) begin
                rx_q <= rx_shift(rx_q, sdi_in, shift_order_select_in);
              end
              // late capture: launch here so sdo is settled at the capture edge
              if (!cap_lead && bit_q != 3'h0) begin
                tx_q <= tx_shift(tx_q, shift_order_select_in);
                sdo_out <= out_bit(tx_shift(tx_q, shift_order_select_in), shift_order_select_in);
              end
              state_q <= ST_TRAIL;
            end
          end
          ST_TRAIL: begin
            if (tick) begin
              sck_out <= idle_lvl;
              // one bit in per bit out
              if (!cap_lead) begin
                rx_q <= rx_shift(rx_q, sdi_in, shift_order_select_in);
              end
              if (bit_q == `SMSPI_BITS) begin
                serial_shift_data_out <= cap_lead ? rx_q : rx_shift(rx_q, sdi_in, shift_order_select_in);
                rx_data_out <= cap_lead ? rx_q : rx_shift(rx_q, sdi_in, shift_order_select_in);
                rx_valid_out <= 1'b1;
                busy_out <= 1'b0;
                state_q <= ST_IDLE;
              end else begin
                if (cap_lead) begin
                  tx_q <= tx_shift(tx_q, shift_order_select_in);
                  sdo_out <= out_bit(tx_shift(tx_q, shift_order_select_in), shift_order_select_in);
                end
                bit_q <= bit_q + 3'h1;
                state_q <= ST_LEAD;
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// ---- dv/smspi_master_sva.sv ----
`timescale 1ns/1ns
module smspi_master_sva (
  input wire sys_clk_in,
  input wire rst_b_in,
  input wire serial_module_enable_in,
  input wire clock_idle_level_select_in,
  input wire wr_valid_in,
  input wire wr_ready_out,
  input wire busy_out,
  input wire rx_valid_out,
  input wire write_collision_clear_in,
  input wire transfer_complete_clear_in,
  input wire write_collision_flag_out,
  input wire transfer_complete_flag_out,
  input wire sck_out,
  input wire sck_oe_out,
  input wire sdo_oe_out,
  input wire sdi_pullup_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  reg       sck_q;
  reg [4:0] tgl_q;
  // sck toggles seen during one transfer
  always @(posedge sys_clk_in) begin
    sck_q <= sck_out;
    tgl_q <= busy_out ? tgl_q + 5'(sck_out != sck_q) : 5'h00;
  end
  sequence s_take;
    wr_valid_in && wr_ready_out && !busy_out && !rx_valid_out;
  endsequence
  sequence s_end;
    $fell(busy_out) ##0 rx_valid_out;
  endsequence
  property p_start;
    s_take |-> ##2 busy_out;
  endproperty
  a_start: assert property (p_start)
    else $error("idle write did not start");
  property p_collide;
    wr_valid_in && busy_out && serial_module_enable_in |=> write_collision_flag_out;
  endproperty
  a_collide: assert property (p_collide)
    else $error("collision not flagged");
  property p_write_collision_flag_hold;
    write_collision_flag_out && !write_collision_clear_in |=> write_collision_flag_out;
  endproperty
  a_write_collision_flag_hold: assert property (p_write_collision_flag_hold)
    else $error("collision flag dropped");
  property p_trf_hold;
    transfer_complete_flag_out && !transfer_complete_clear_in |=> transfer_complete_flag_out;
  endproperty
  a_trf_hold: assert property (p_trf_hold)
    else $error("done flag dropped");
  property p_done;
    $rose(transfer_complete_flag_out) |-> s_end;
  endproperty
  a_done: assert property (p_done)
    else $error("done flag off transfer end");
  property p_count;
    $fell(busy_out) && serial_module_enable_in && $past(serial_module_enable_in)
      |-> tgl_q + 5'(sck_out != sck_q) == 5'h10;
  endproperty
  a_count: assert property (p_count)
    else $error("not eight clock periods");
  property p_idle;
    sck_oe_out && $past(sck_oe_out) && !busy_out && !$past(busy_out) && $stable(clock_idle_level_select_in)
      |-> sck_out == !clock_idle_level_select_in;
  endproperty
  a_idle: assert property (p_idle)
    else $error("sck not at idle level");
  property p_off;
    !serial_module_enable_in && !$past(serial_module_enable_in) |-> !sck_oe_out && !sdo_oe_out && !sdi_pullup_out;
  endproperty
  a_off: assert property (p_off)
    else $error("pins driven while disabled");
endmodule

// ---- dv/smspi_slave_model.sv ----
`timescale 1ns/1ns
module smspi_slave_model (
  input  wire       sck_in,
  input  wire       sdo_in,
  input  wire       ss_b_in,
  input  wire       pol_in,
  input  wire       edge_in,
  input  wire       msb_in,
  output wire       sdi_out,
  output reg  [7:0] got_out = 8'h3C
);
  reg  [7:0] o = 8'h3C;
  reg  [7:0] r = 8'h00;
  int        ld = 0;
  int        tr = 0;
  wire       lead_cap = (pol_in == edge_in) == pol_in;
  wire [2:0] j = lead_cap ? 3'(tr) : 3'(ld - 1);
  assign sdi_out = ss_b_in ? 1'h1 : o[msb_in ? 3'h7 - j : j];
  always @(posedge ss_b_in) begin
    ld = 0;
    tr = 0;
  end
  always @(sck_in) begin
    if (!ss_b_in) begin
      if (sck_in == pol_in) ld++;
      else tr++;
      if ((sck_in == pol_in) == lead_cap) r = msb_in ? {r[6:0], sdo_in} : {sdo_in, r[7:1]};
      // echo: the byte just taken is the next one sent
      if (tr == 8) begin
        got_out = r;
        o = r;
        ld = 0;
        tr = 0;
      end
    end
  end
endmodule

// ---- dv/serial_module_spi_master_test.sv ----
`timescale 1ns/1ns
`include "smspi_consts.vh"
module serial_module_spi_master_test;
  logic       sys_clk_in = 1'h0, rst_b_in = 1'h0, serial_module_enable_in = 1'h1, wr_valid_in = 1'h0;
  logic       clock_idle_level_select_in = 1'h0, clock_capture_edge_select_in = 1'h0, shift_order_select_in = 1'h0;
  logic       sub_clock_in = 1'h0, timer_period_match_in = 1'h0, slave_select_level_in = 1'h1, rx_ready_in = 1'h0;
  logic       write_collision_clear_in = 1'h0, transfer_complete_clear_in = 1'h0;
  logic [2:0] serial_mode_select_in = 3'h0;
  logic [7:0] wr_data_in = 8'h00, prev = 8'h3C;
  wire        sdi_in, wr_ready_out, rx_valid_out, write_collision_flag_out, transfer_complete_flag_out, busy_out;
  wire        sdo_out, sdo_oe_out, sck_out, sck_oe_out, sdi_pullup_out, slave_select_out, slave_select_oe_out;
  wire  [7:0] serial_shift_data_out, rx_data_out, got;
  int         errors = 0, checked = 0, cyc = 0, n;
  smspi_master smspi_master_inst (.*);
  smspi_slave_model smspi_slave_model_inst (.sck_in(sck_out), .sdo_in(sdo_out), .ss_b_in(slave_select_out),
    .pol_in(clock_idle_level_select_in), .edge_in(clock_capture_edge_select_in), .msb_in(shift_order_select_in),
    .sdi_out(sdi_in), .got_out(got));
  always #20 sys_clk_in = ~sys_clk_in;
  // slow sources: sub clock edge and timer match every 4 cycles
  always @(posedge sys_clk_in) begin
    #5;
    cyc++;
    sub_clock_in = cyc[2];
    timer_period_match_in = cyc[1:0] == 2'h0;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_in);
    #5;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic put(input logic [7:0] d);
    wr_data_in = d;
    wr_valid_in = 1'h1;
    tick(1);
    wr_valid_in = 1'h0;
  endtask
  task automatic xfer(input logic [7:0] d, input bit coll);
    put(d);
    n = 0;
    while (busy_out !== 1'h1 && n++ < 9) tick(1);
    if (coll) begin
      tick(3);
      put(8'hFF);
    end
    n = 0;
    while (busy_out !== 1'h0 && n++ < 2000) tick(1);
    chk(rx_valid_out, 1'h1, "rx valid");
    chk(rx_data_out, prev, "rx data");
    chk(serial_shift_data_out, prev, "data reg");
    chk(transfer_complete_flag_out, 1'h1, "done");
    chk(got, d, "slave byte");
    rx_ready_in = 1'h1;
    transfer_complete_clear_in = 1'h1;
    tick(1);
    rx_ready_in = 1'h0;
    transfer_complete_clear_in = 1'h0;
    chk(transfer_complete_flag_out, 1'h0, "done clear");
    prev = d;
  endtask
  task automatic conclude;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #(40 * 20000);
    errors++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge sys_clk_in);
    #5 rst_b_in = 1'h1;
    tick(1);
    for (int i = 0; i < 8; i++) begin
      slave_select_level_in = 1'h1;
      tick(2);
      {clock_idle_level_select_in, clock_capture_edge_select_in, shift_order_select_in} = 3'(i);
      tick(2);
      slave_select_level_in = 1'h0;
      tick(2);
      xfer(8'(8'h1B * i + 8'h4D), 1'h0);
    end
    for (int m = 1; m < 5; m++) begin
      serial_mode_select_in = 3'(m);
      tick(2);
      xfer(8'(8'hE1 - m), 1'h0);
      if (m < 3) chk(16'(n), 16'(32 << (2 * m)), "sck rate");
      else chk(16'(n > 60 && n < 65), 16'h0001, "sck rate");
    end
    serial_mode_select_in = `SMSPI_MODE_DIV4;
    xfer(8'h96, 1'h1);
    chk(write_collision_flag_out, 1'h1, "collision");
    write_collision_clear_in = 1'h1;
    tick(1);
    write_collision_clear_in = 1'h0;
    chk(write_collision_flag_out, 1'h0, "collision clr");
    // unread byte stalls the shifter so the queue fills
    put(8'h00);
    n = 0;
    while (rx_valid_out !== 1'h1 && n++ < 99) tick(1);
    wr_valid_in = 1'h1;
    for (int j = 1; j < 9; j++) begin
      wr_data_in = 8'(j);
      tick(1);
    end
    wr_valid_in = 1'h0;
    tick(1);
    chk(wr_ready_out, 1'h0, "queue full");
    for (int j = 0; j < 9; j++) begin
      n = 0;
      while (rx_valid_out !== 1'h1 && n++ < 99) tick(1);
      chk(rx_data_out, prev, "queued rx");
      prev = 8'(j);
      rx_ready_in = 1'h1;
      tick(1);
      rx_ready_in = 1'h0;
    end
    tick(40);
    chk(got, 8'h08, "last byte");
    slave_select_level_in = 1'h1;
    for (int k = 0; k < 2; k++) begin
      serial_module_enable_in = k[0];
      serial_mode_select_in = k ? `SMSPI_MODE_I2C : `SMSPI_MODE_DIV4;
      tick(2);
      put(8'h77);
      tick(4);
      chk({busy_out, sck_oe_out, sdo_oe_out, sdi_pullup_out}, 8'h00, "pins off");
      chk(slave_select_oe_out, 1'h1, "select oe");
    end
    conclude();
  end
endmodule
bind smspi_master smspi_master_sva smspi_master_sva_inst (.*);
